// [ppr_lsu_model.sv]
`timescale 1ns/100ps
module ppr_lsu_model (
    input  wire logic        clk_in,
    input  wire logic        issue_in,
    input  wire logic [31:0] addr_in,
    input  wire logic [5:0]  ctl_in,
    output logic             valid_out = 1'h0,
    output logic [31:0]      addr_out = 32'h0,
    output logic [5:0]       ctl_out = 6'h0
);
    // idle bus shows inverted leftovers, flipping back to a stale copy every second idle cycle
    always @(posedge clk_in) begin
        valid_out <= issue_in;
        addr_out  <= issue_in ? addr_in : ~addr_out;
        ctl_out   <= issue_in ? ctl_in : ~ctl_out;
    end
endmodule : ppr_lsu_model

// [ppr_pkg.sv]
package ppr_pkg;
    localparam int          PPR_DATA_W      = 32;
    localparam logic [2:0]  PPR_OPC1        = 3'h0;
    localparam logic [3:0]  PPR_CRN         = 4'hF;
    localparam logic [3:0]  PPR_CRM         = 4'h2;
    localparam logic [2:0]  PPR_OPC2        = 3'h4;
    localparam int          PPR_BASE_LSB    = 12;
    localparam int          PPR_BASE_W      = 20;
    localparam int          PPR_SIZE_LSB    = 0;
    localparam int          PPR_SIZE_W      = 5;
    localparam logic [4:0]  PPR_SIZE_NONE   = 5'h00;
    localparam logic [4:0]  PPR_SIZE_MIN    = 5'h03;
    localparam logic [4:0]  PPR_SIZE_MAX    = 5'h16;
    localparam logic [19:0] PPR_BASE_RST    = 20'h00000;
    localparam logic [4:0]  PPR_SIZE_RST    = 5'h00;
    localparam int          PPR_SIZE_TO_LOG2 = 9;
    localparam logic [1:0]  PPR_ATTR_DEVICE_NS = 2'h1;

    typedef enum logic [1:0] {
        PPR_ST_IDLE = 2'b00,
        PPR_ST_DONE = 2'b01
    } ppr_state_type;
endpackage : ppr_pkg

// [ppr_region_match.sv]
`timescale 1ns/100ps
module ppr_region_match
    import ppr_pkg::*;
(
    input  wire logic [19:0] base_in,
    input  wire logic [4:0]  size_in,
    input  wire logic [19:0] addr_page_in,
    output logic             hit_out
);
    logic [19:0] mask;

    // size code n covers 2^(n+9) bytes; page bits below that are ignored
    for (genvar i = 0; i < PPR_BASE_W; i++) begin : g_mask
        assign mask[i] = (5'(i) + PPR_SIZE_MIN < size_in) ? 1'h0 : 1'h1;
    end

    always_comb begin
        hit_out = 1'b0;
        if (size_in >= PPR_SIZE_MIN && size_in <= PPR_SIZE_MAX) begin
            hit_out = ((addr_page_in ^ base_in) & mask) == 20'h00000;
        end
    end
endmodule : ppr_region_match

// [ppr_remap.sv]
`timescale 1ns/100ps
// Operation
// - Region hits take Non-Shared Device and go to the peripheral port.
// - The override applies whether translation is enabled or not.
// - The region override beats the primary and normal remap results.
// - Two 32-bit copies exist, Secure and Non-secure, picked by the world.
// - Bits 31:12 hold the physical region start and reset to zero.
// - With translation off the virtual start equals the physical start.
// - Start bits from 12 up to log2(size)-1 are ignored in the compare.
// - Size codes 3 to 22 select 4KB doubling up to 2GB.
// - Size resets to zero, meaning no remapping.
// - A Secure write with the write lock high is undefined and ignored; the code uses a filtered lock that follows the pin 4 cycles late.
// - User mode reads and writes are undefined in both worlds.
// - Only opcode1 0, c15, c2, opcode2 4 selects this register.
module ppr_remap
    import ppr_pkg::*;
(
    input  wire logic        core_clk_in,
    input  wire logic        nrst_in,
    input  wire logic        coproc_valid_in,
    input  wire logic        coproc_write_in,
    input  wire logic [2:0]  coproc_opc1_in,
    input  wire logic [3:0]  primary_coproc_reg_in,
    input  wire logic [3:0]  secondary_coproc_reg_in,
    input  wire logic [2:0]  coproc_opc2_in,
    input  wire logic        coproc_secure_in,
    input  wire logic        coproc_priv_in,
    input  wire logic [31:0] coproc_wdata_in,
    input  wire logic        secure_coproc_write_lock_in,
    input  wire logic        acc_valid_in,
    input  wire logic [31:0] acc_addr_in,
    input  wire logic        acc_secure_in,
    input  wire logic        acc_mmu_on_in,
    input  wire logic [1:0]  acc_attr_in,
    input  wire logic        acc_shared_in,
    input  wire logic        acc_remap_hit_in,
    output logic             coproc_ack_out,
    output logic             coproc_undef_out,
    output logic [31:0]      coproc_rdata_out,
    output logic             acc_valid_out,
    output logic [31:0]      acc_addr_out,
    output logic [1:0]       acc_attr_out,
    output logic             acc_shared_out,
    output logic             acc_periph_port_out
);
    logic [19:0] base_s;
    logic [19:0] base_ns;
    logic [4:0]  size_s;
    logic [4:0]  size_ns;
    logic [19:0] sel_base;
    logic [4:0]  sel_size;
    logic        lock_q1;
    logic        lock_q2;
    logic        lock_q3;
    logic        lock;
    logic        sel_hit;
    logic        my_reg;
    logic        legal;
    logic        wr_ok;
    logic        chk_in_range;
    logic [5:0]  chk_log2;
    logic [31:0] chk_span;
    logic        chk_hit;

    // the read mux assumes this layout; refuse edits it cannot serve
    if (PPR_BASE_LSB + PPR_BASE_W != PPR_DATA_W) begin : g_base_top
        $error("base field must reach the top bit");
    end
    if (PPR_SIZE_LSB + PPR_SIZE_W + 7 != PPR_BASE_LSB) begin : g_size_gap
        $error("size field and gap must fill the bits below base");
    end
    if (PPR_SIZE_MIN > PPR_SIZE_MAX) begin : g_size_span
        $error("size code range is empty");
    end
    if (int'(PPR_SIZE_MAX) + PPR_SIZE_TO_LOG2 >= PPR_DATA_W) begin : g_size_top
        $error("largest region does not fit the address");
    end

    // every check below runs on the core clock and rests during reset
    default clocking ast_clk @(posedge core_clk_in);
    endclocking
    default disable iff (!nrst_in);

    // lock is a pin from outside; filter so a glitch cannot block a write
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            lock_q1 <= 1'b0;
            lock_q2 <= 1'b0;
            lock_q3 <= 1'b0;
            lock    <= 1'b0;
        end else begin
            lock_q1 <= secure_coproc_write_lock_in;
            lock_q2 <= lock_q1;
            lock_q3 <= lock_q2;
            if (lock_q2 == lock_q3) begin
                lock <= lock_q3;
            end
        end
    end

    assign my_reg = coproc_opc1_in == PPR_OPC1
                 && primary_coproc_reg_in == PPR_CRN
                 && secondary_coproc_reg_in == PPR_CRM
                 && coproc_opc2_in == PPR_OPC2;
    assign legal  = coproc_priv_in
                 && !(coproc_write_in && coproc_secure_in && lock);
    assign wr_ok  = coproc_valid_in && my_reg && legal && coproc_write_in;

    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            base_s  <= PPR_BASE_RST;
            size_s  <= PPR_SIZE_RST;
            base_ns <= PPR_BASE_RST;
            size_ns <= PPR_SIZE_RST;
        end else if (wr_ok) begin
            if (coproc_secure_in) begin
                base_s <= coproc_wdata_in[PPR_BASE_LSB +: PPR_BASE_W];
                size_s <= coproc_wdata_in[PPR_SIZE_LSB +: PPR_SIZE_W];
            end else begin
                base_ns <= coproc_wdata_in[PPR_BASE_LSB +: PPR_BASE_W];
                size_ns <= coproc_wdata_in[PPR_SIZE_LSB +: PPR_SIZE_W];
            end
        end
    end

    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            coproc_ack_out   <= 1'b0;
            coproc_undef_out <= 1'b0;
            coproc_rdata_out <= 32'h00000000;
        end else begin
            coproc_ack_out   <= coproc_valid_in && my_reg;
            coproc_undef_out <= coproc_valid_in && my_reg && !legal;
            coproc_rdata_out <= 32'h00000000;
            if (coproc_valid_in && my_reg && legal && !coproc_write_in) begin
                coproc_rdata_out <= coproc_secure_in
                    ? {base_s, 7'h00, size_s}
                    : {base_ns, 7'h00, size_ns};
            end
        end
    end

    assign sel_base = acc_secure_in ? base_s : base_ns;
    assign sel_size = acc_secure_in ? size_s : size_ns;

    // address compared as given; with mmu off it is both virtual and physical
    ppr_region_match u_match (
        .base_in      (sel_base),
        .size_in      (sel_size),
        .addr_page_in (acc_addr_in[31:12]),
        .hit_out      (sel_hit)
    );

    // shift-based second view of the match, read only by the checks below
    assign chk_in_range = sel_size >= PPR_SIZE_MIN && sel_size <= PPR_SIZE_MAX;
    assign chk_log2     = 6'(sel_size) + 6'(PPR_SIZE_TO_LOG2);
    assign chk_span     = 32'hFFFFFFFF << chk_log2;
    assign chk_hit      = chk_in_range
                       && ((acc_addr_in ^ {sel_base, 12'h000}) & chk_span)
                          == 32'h00000000;

    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            acc_valid_out       <= 1'b0;
            acc_addr_out        <= 32'h00000000;
            acc_attr_out        <= 2'h0;
            acc_shared_out      <= 1'b0;
            acc_periph_port_out <= 1'b0;
        end else begin
            acc_valid_out <= acc_valid_in;
            acc_addr_out  <= acc_addr_in;
            // mmu state deliberately not consulted
            if (acc_valid_in && sel_hit) begin
                acc_attr_out        <= PPR_ATTR_DEVICE_NS;
                acc_shared_out      <= 1'b0;
                acc_periph_port_out <= 1'b1;
            end else begin
                acc_attr_out        <= acc_attr_in;
                acc_shared_out      <= acc_shared_in;
                acc_periph_port_out <= 1'b0;
            end
        end
    end

    // access path
    AST_HIT_DEVICE: assert property (
        acc_valid_in && sel_hit |=> acc_periph_port_out
            && acc_attr_out == PPR_ATTR_DEVICE_NS && !acc_shared_out)
        else $error("region hit not forced to device");
    AST_MISS_PASS: assert property (
        acc_valid_in && !sel_hit |=> !acc_periph_port_out
            && acc_attr_out == $past(acc_attr_in)
            && acc_shared_out == $past(acc_shared_in))
        else $error("miss did not keep table attributes");
    AST_ADDR_COPY: assert property (
        acc_valid_in |=> acc_valid_out && acc_addr_out == $past(acc_addr_in))
        else $error("access not passed through");
    AST_IDLE_NOPORT: assert property (
        !acc_valid_in |=> !acc_periph_port_out && !acc_valid_out)
        else $error("idle cycle sent to the port");
    AST_MMU_OFF: assert property (
        acc_valid_in && !acc_mmu_on_in && sel_hit |=> acc_periph_port_out)
        else $error("override lost with mmu off");
    AST_MMU_ON: assert property (
        acc_valid_in && acc_mmu_on_in && sel_hit |=> acc_periph_port_out)
        else $error("override lost with mmu on");
    AST_PRIORITY: assert property (
        acc_valid_in && acc_remap_hit_in && sel_hit
            |=> acc_attr_out == PPR_ATTR_DEVICE_NS)
        else $error("remap beat the region");
    AST_PRIO_PORT: assert property (
        acc_valid_in && acc_remap_hit_in && sel_hit
            |=> acc_periph_port_out && !acc_shared_out)
        else $error("remap kept the access off the port");
    AST_VIRT_EQ_PHYS: assert property (
        acc_valid_in && !acc_mmu_on_in && chk_hit |=> acc_periph_port_out)
        else $error("untranslated address missed its region");
    AST_REF_MATCH: assert property (
        acc_valid_in |-> sel_hit == chk_hit)
        else $error("mask match and shift match disagree");
    AST_4K_HIT: assert property (
        acc_valid_in && sel_size == PPR_SIZE_MIN
            && acc_addr_in[31:12] == sel_base |=> acc_periph_port_out)
        else $error("4KB region missed");
    AST_ZERO_NOHIT: assert property (
        acc_valid_in && sel_size == PPR_SIZE_NONE |=> !acc_periph_port_out)
        else $error("zero size remapped");
    AST_RSVD_NOHIT: assert property (
        acc_valid_in && !chk_in_range |=> !acc_periph_port_out)
        else $error("unlisted size remapped");

    // register bank
    AST_BANKED: assert property (
        wr_ok && coproc_secure_in |=> $stable(base_ns) && $stable(size_ns))
        else $error("secure write hit nonsecure copy");
    AST_BANKED_NS: assert property (
        wr_ok && !coproc_secure_in |=> $stable(base_s) && $stable(size_s))
        else $error("nonsecure write hit secure copy");
    AST_BASE_WR: assert property (
        wr_ok && !coproc_secure_in
            |=> base_ns == $past(coproc_wdata_in[31:12]))
        else $error("base not stored");
    AST_BASE_WR_S: assert property (
        wr_ok && coproc_secure_in
            |=> base_s == $past(coproc_wdata_in[PPR_BASE_LSB +: PPR_BASE_W]))
        else $error("secure base not stored");
    AST_SIZE_WR: assert property (
        wr_ok && coproc_secure_in
            |=> size_s == $past(coproc_wdata_in[PPR_SIZE_LSB +: PPR_SIZE_W]))
        else $error("size code not stored");
    AST_READ_BASE: assert property (
        coproc_valid_in && my_reg && legal && !coproc_write_in
            |=> coproc_rdata_out[PPR_BASE_LSB +: PPR_BASE_W]
                == $past(coproc_secure_in ? base_s : base_ns))
        else $error("read returned the wrong base");
    AST_READ_SIZE: assert property (
        coproc_valid_in && my_reg && legal && !coproc_write_in
            |=> coproc_rdata_out[PPR_SIZE_LSB +: PPR_SIZE_W]
                == $past(coproc_secure_in ? size_s : size_ns))
        else $error("read returned the wrong size");
    AST_GAP_ZERO: assert property (
        coproc_ack_out |-> coproc_rdata_out[11:5] == 7'h00)
        else $error("unused bits read nonzero");
    AST_WRITE_NODATA: assert property (
        coproc_valid_in && coproc_write_in |=> coproc_rdata_out == 32'h00000000)
        else $error("write returned data");

    // access rights
    AST_LOCK: assert property (
        coproc_valid_in && my_reg && coproc_write_in && coproc_secure_in
            && coproc_priv_in && lock |=> coproc_undef_out && $stable(base_s))
        else $error("locked write not refused");
    AST_LOCK_KEEP: assert property (
        coproc_valid_in && my_reg && coproc_write_in && coproc_secure_in
            && lock |=> $stable(size_s))
        else $error("locked write changed the size");
    AST_LOCK_NS: assert property (
        coproc_valid_in && my_reg && coproc_write_in && !coproc_secure_in
            && coproc_priv_in |=> !coproc_undef_out)
        else $error("lock refused a nonsecure write");
    AST_LOCK_FILTER: assert property (
        $changed(lock)
            |-> $past(lock_q2 == lock_q3) && lock == $past(lock_q3))
        else $error("lock moved before the pin settled");
    AST_USER: assert property (
        coproc_valid_in && my_reg && !coproc_priv_in
            |=> coproc_undef_out ##0 $stable(size_s) && $stable(size_ns))
        else $error("user access not refused");
    AST_USER_NOWR: assert property (
        coproc_valid_in && !coproc_priv_in
            |=> $stable(base_s) && $stable(base_ns))
        else $error("user access changed a base");
    AST_UNDEF_ACK: assert property (
        coproc_undef_out
            |-> coproc_ack_out && coproc_rdata_out == 32'h00000000)
        else $error("refusal not acked or leaked data");
    AST_DECODE: assert property (
        coproc_valid_in && !my_reg |=> !coproc_ack_out)
        else $error("foreign encoding acked");
    AST_DECODE_ACK: assert property (
        coproc_valid_in && my_reg |=> coproc_ack_out)
        else $error("own encoding not acked");
    AST_NO_REQ_QUIET: assert property (
        !coproc_valid_in |=> !coproc_ack_out && !coproc_undef_out)
        else $error("answer without a request");
endmodule : ppr_remap

// [tb_top.sv]
`timescale 1ns/100ps
module tb_top;
    import ppr_pkg::*;
    logic        clk = 1'h0, rst_n = 1'h0, cv = 1'h0, cw = 1'h0;
    logic        cs = 1'h0, cpv = 1'h0, lock = 1'h0, iss = 1'h0;
    logic [2:0]  o1 = 3'h0, o2 = 3'h0;
    logic [3:0]  rn = 4'h0, rm = 4'h0;
    logic [31:0] wd = 32'h0, pa = 32'h0, aad, rd, oa;
    logic [5:0]  pc = 6'h0, ctl;
    logic        av, ack, und, oh, pp, ov;
    logic [1:0]  ot;
    logic [31:0] bank [2];
    logic [32:0] cq [$];
    logic [35:0] aq [$];
    int          err_count = 0, compares = 0, cyc = 0, seed = 20248;
    initial forever #5 clk = ~clk;
    ppr_lsu_model lsu (.clk_in(clk), .issue_in(iss), .addr_in(pa),
        .ctl_in(pc), .valid_out(av), .addr_out(aad), .ctl_out(ctl));
    ppr_remap uut (.core_clk_in(clk), .nrst_in(rst_n),
        .coproc_valid_in(cv), .coproc_write_in(cw), .coproc_opc1_in(o1),
        .primary_coproc_reg_in(rn), .secondary_coproc_reg_in(rm),
        .coproc_opc2_in(o2), .coproc_secure_in(cs), .coproc_priv_in(cpv),
        .coproc_wdata_in(wd), .secure_coproc_write_lock_in(lock),
        .acc_valid_in(av), .acc_addr_in(aad), .acc_secure_in(ctl[0]),
        .acc_mmu_on_in(ctl[1]), .acc_attr_in(ctl[3:2]),
        .acc_shared_in(ctl[4]), .acc_remap_hit_in(ctl[5]),
        .coproc_ack_out(ack), .coproc_undef_out(und),
        .coproc_rdata_out(rd), .acc_valid_out(ov), .acc_addr_out(oa),
        .acc_attr_out(ot), .acc_shared_out(oh), .acc_periph_port_out(pp));
    function automatic logic hit(input logic [31:0] r, input logic [31:0] a);
        int lg;
        lg = int'(r[4:0]) + PPR_SIZE_TO_LOG2;
        // reserved and zero sizes match nothing
        if (r[4:0] < PPR_SIZE_MIN || r[4:0] > PPR_SIZE_MAX) return 1'h0;
        return (a >> lg) == (r >> lg);
    endfunction : hit
    task automatic chk(input logic ok, input string m);
        compares++;
        if (ok !== 1'h1) begin
            err_count++;
            $display("[FAIL] %0t %s", $time, m);
        end
    endtask : chk
    task automatic final_report();
        chk(cq.size() + aq.size() == 0, "answers missing");
        if (err_count == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : final_report
    // mode is {write, secure, privileged}
    task automatic cop(input logic [2:0] md, input int bad,
                       input logic [31:0] d);
        @(posedge clk);
        cv  <= 1'h1;
        cw  <= md[2];
        cs  <= md[1];
        cpv <= md[0];
        wd  <= d;
        o1  <= PPR_OPC1 ^ 3'(bad == 1);
        rn  <= PPR_CRN ^ 4'(bad == 2);
        rm  <= PPR_CRM ^ 4'(bad == 3);
        o2  <= PPR_OPC2 ^ 3'(bad == 4);
        if (bad == 0) begin
            if (!md[0] || (md[2] && md[1] && lock)) begin
                cq.push_back(33'h100000000);
            end else if (md[2]) begin
                bank[md[1]] = d & 32'hFFFFF01F;
                cq.push_back(33'h0);
            end else begin
                cq.push_back({1'h0, bank[md[1]]});
            end
        end
        @(posedge clk);
        cv  <= 1'h0;
    endtask : cop
    task automatic acc(input logic [31:0] a, input logic s);
        logic [5:0] c;
        logic       h;
        c = {5'($random(seed)), s};
        h = hit(bank[s], a);
        aq.push_back({h, a, h ? PPR_ATTR_DEVICE_NS : c[3:2], c[4] & !h});
        @(posedge clk);
        iss <= 1'h1;
        pa  <= a;
        pc  <= c;
        @(posedge clk);
        iss <= 1'h0;
    endtask : acc
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (rst_n && ack)
            chk(cq.size() && {und, rd} === cq.pop_front(), "cp");
        if (rst_n && ov)
            chk(aq.size() && {pp, oa, ot, oh} === aq.pop_front(),
                "acc");
        if (cyc == 3000) begin
            err_count++;
            final_report();
        end
    end
    initial begin
        logic [31:0] m;
        logic [31:0] r;
        bank[0] = 32'h0;
        bank[1] = 32'h0;
        repeat (10) @(posedge clk);
        rst_n <= 1'h1;
        cop(3'h3, 0, 32'h0);
        cop(3'h1, 0, 32'h0);
        cop(3'h5, 0, 32'hA5A5AFF6);
        cop(3'h7, 0, 32'h5A5A5FE3);
        cop(3'h1, 0, 32'h0);
        cop(3'h3, 0, 32'h0);
        for (int b = 1; b < 5; b++) cop(3'h7, b, 32'hFFFFF016);
        cop(3'h4, 0, 32'h1);
        cop(3'h2, 0, 32'h0);
        cop(3'h3, 0, 32'h0);
        lock <= 1'h1;
        repeat (6) @(posedge clk);
        cop(3'h7, 0, 32'h3);
        cop(3'h5, 0, 32'h00001016);
        cop(3'h3, 0, 32'h0);
        cop(3'h1, 0, 32'h0);
        lock <= 1'h0;
        repeat (6) @(posedge clk);
        for (int s = 0; s < 23; s++) begin
            if (s == 1 || s == 2) continue;
            m = (s == 0) ? 32'hFFF : (32'h1 << (s + 9)) - 32'h1;
            r = $random(seed) & ~m;
            cop(3'h7, 0, r | 32'(s));
            acc(r | ($random(seed) & m), 1'h1);
            acc(r ^ (m + 32'h1), 1'h1);
            acc(r | m, 1'h0);
            acc($random(seed), 1'h1);
        end
        repeat (5) @(posedge clk);
        final_report();
    end
endmodule : tb_top
